// ### logic/cdp_clk_div.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Divider that makes the configuration clock in the active schemes.
// ----------------------------------------------------------------------------
module cdp_clk_div #(
	parameter HALF_PERIOD = 4
) (
	input  wire ref_clk,
	input  wire nrst,
	input  wire run,
	output reg  level,
	output reg  rise,
	output reg  fall
);

	reg [7:0] count;
	wire      wrap;

	assign wrap = (count == HALF_PERIOD[7:0] - 8'h01);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count <= 8'h00;
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else if (!run) begin
			count <= 8'h00;
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			count <= wrap ? 8'h00 : count + 8'h01;
			rise  <= wrap & ~level;
			fall  <= wrap & level;
			if (wrap) begin
				level <= ~level;
			end
		end
	end

endmodule // cdp_clk_div

// ### logic/cdp_config_port.v
// Overview of operation
// - Passive schemes: host drives config clock; data sampled on each rising edge.
// - Active serial: device generates and drives out the config clock.
// - Active parallel: device generates and drives out the config clock.
// - Active schemes: clock pin goes inactive after completion, or is released.
// - After completion, toggling of the config clock pin is ignored.
// - Serial schemes move one bit per clock on data bit zero.
// - Active serial: data bit one carries the read command to memory.
// - After active serial: data bit zero stays a dedicated input.
// - After active serial: data bit one stays a dedicated output.
// - After passive schemes: data bit zero becomes a user pin.
// - Passive serial: data bit one tri-stated during configuration.
// - Active parallel moves a byte on bits 7:0 or word on 15:0.
// - Serial schemes: data bits 7:2 tri-stated during configuration.
// - After passive parallel: data bits 7:2 become user pins.
// - Non active parallel schemes: bits 15:8 tri-stated during configuration.
// - After active parallel: whole data bus is user-controlled bidirectional.
// - Active parallel: flash select driven active while data is fetched.
// - Completion flag held low until all data received, then released.
`timescale 1ns/1ps
`include "cdp_defs.vh"

module cdp_config_port #(
	parameter CLOCK_HALF_PERIOD = 4
) (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire [1:0]  scheme_strap,
	input  wire        word_mode_strap,
	input  wire        config_clock_in,
	output reg         config_clock_out,
	output reg         config_clock_oe,
	input  wire [15:0] data_pin_in,
	output reg  [15:0] data_pin_out,
	output reg  [15:0] data_pin_oe,
	output reg         flash_select_n,
	output reg         config_complete_flag_out,
	output reg         config_complete_flag_oe,
	input  wire        load_done,
	input  wire        clock_release_en,
	input  wire        user_clock_out,
	input  wire [15:0] user_data_out,
	input  wire [15:0] user_data_oe,
	output reg  [15:0] user_data_in,
	output reg         user_mode,
	output reg  [15:0] cfg_data,
	output reg         cfg_data_valid,
	output reg         cfg_data_wide
);

	// ------------------------------------------------------------------------
	// Controller states.
	// ------------------------------------------------------------------------
	localparam [1:0] ST_CAPTURE = `CDP_ST_CAPTURE;
	localparam [1:0] ST_LOAD    = `CDP_ST_LOAD;
	localparam [1:0] ST_USER    = `CDP_ST_USER;

	// ------------------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------------------
	wire        clock_sync;
	wire [15:0] data_sync;
	wire [2:0]  strap_sync;

	cdp_sync2 #(.WIDTH(1)) u_sync_clock (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in (config_clock_in),
		.sync_out (clock_sync)
	);

	cdp_sync2 #(.WIDTH(`CDP_BUS_WIDTH)) u_sync_data (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in (data_pin_in),
		.sync_out (data_sync)
	);

	cdp_sync2 #(.WIDTH(3)) u_sync_strap (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in ({word_mode_strap, scheme_strap}),
		.sync_out (strap_sync)
	);

	// ------------------------------------------------------------------------
	// State and held scheme.
	// ------------------------------------------------------------------------
	reg  [1:0]  state;
	reg  [1:0]  scheme;
	reg         word_mode;
	reg         clock_prev;
	reg  [31:0] cmd_shift;
	reg  [5:0]  cmd_count;
	reg         read_phase;
	reg  [7:0]  bit_shift;
	reg  [2:0]  bit_count;
	reg  [1:0]  settle_count;

	wire        loading;
	wire        active_scheme;
	wire        serial_scheme;
	wire        host_rise;
	wire        gen_level;
	wire        gen_rise;
	wire        gen_fall;
	wire        sample;
	wire        cmd_left;
	wire [15:0] user_mask;

	assign loading       = (state == ST_LOAD);
	assign active_scheme = (scheme == `CDP_ACTIVE_SERIAL_SCHEME) | (scheme == `CDP_ACTIVE_PARALLEL_SCHEME);
	assign serial_scheme = (scheme == `CDP_ACTIVE_SERIAL_SCHEME) | (scheme == `CDP_PASSIVE_SERIAL_SCHEME);
	assign cmd_left      = (cmd_count != `CDP_CMD_BITS);

	// ------------------------------------------------------------------------
	// Clock edges.
	// ------------------------------------------------------------------------
	// Host clock edge.
	assign host_rise = loading & ~active_scheme & clock_sync & ~clock_prev;

	cdp_clk_div #(.HALF_PERIOD(CLOCK_HALF_PERIOD)) u_clk_div (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.run     (loading & active_scheme),
		.level   (gen_level),
		.rise    (gen_rise),
		.fall    (gen_fall)
	);

	assign sample = host_rise |
		(gen_rise & (scheme == `CDP_ACTIVE_PARALLEL_SCHEME)) |
		(gen_rise & (scheme == `CDP_ACTIVE_SERIAL_SCHEME) & read_phase);

	// ------------------------------------------------------------------------
	// Control state machine.
	// ------------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state        <= ST_CAPTURE;
			scheme       <= `CDP_PASSIVE_SERIAL_SCHEME;
			word_mode    <= 1'b0;
			clock_prev   <= 1'b0;
			settle_count <= 2'h0;
			user_mode    <= 1'b0;
		end else begin
			clock_prev <= clock_sync;
			case (state)
				ST_CAPTURE: begin
					if (settle_count == `CDP_SETTLE_COUNT) begin
						scheme    <= strap_sync[1:0];
						word_mode <= strap_sync[2];
						state     <= ST_LOAD;
					end else begin
						settle_count <= settle_count + 2'h1;
					end
				end
				ST_LOAD: begin
					if (load_done) begin
						state     <= ST_USER;
						user_mode <= 1'b1;
					end
				end
				ST_USER: begin
					state <= ST_USER;
				end
				default: begin
					state <= ST_CAPTURE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Serial memory read command.
	// ------------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_shift  <= {`CDP_READ_OPCODE, `CDP_READ_ADDRESS};
			cmd_count  <= 6'h00;
			read_phase <= 1'b0;
		end else if (loading & (scheme == `CDP_ACTIVE_SERIAL_SCHEME) & gen_fall) begin
			if (cmd_left) begin
				cmd_shift <= {cmd_shift[`CDP_CMD_MSB-1:0], 1'b0};
				cmd_count <= cmd_count + 6'h01;
			end else begin
				read_phase <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Data capture.
	// ------------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bit_shift      <= 8'h00;
			bit_count      <= 3'h0;
			cfg_data       <= 16'h0000;
			cfg_data_valid <= 1'b0;
			cfg_data_wide  <= 1'b0;
		end else begin
			cfg_data_valid <= 1'b0;
			if (sample) begin
				if (serial_scheme) begin
					bit_shift <= {data_sync[`CDP_SERIAL_BIT], bit_shift[`CDP_BYTE_MSB:1]};
					bit_count <= bit_count + 3'h1;
					if (bit_count == `CDP_LAST_BIT_INDEX) begin
						cfg_data       <= {`CDP_BYTE_PAD, data_sync[`CDP_SERIAL_BIT],
							bit_shift[`CDP_BYTE_MSB:1]};
						cfg_data_valid <= 1'b1;
						cfg_data_wide  <= 1'b0;
					end
				end else if ((scheme == `CDP_ACTIVE_PARALLEL_SCHEME) & word_mode) begin
					cfg_data       <= data_sync;
					cfg_data_valid <= 1'b1;
					cfg_data_wide  <= 1'b1;
				end else begin
					cfg_data       <= {`CDP_BYTE_PAD, data_sync[`CDP_BYTE_MSB:0]};
					cfg_data_valid <= 1'b1;
					cfg_data_wide  <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Configuration clock pin.
	// ------------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			config_clock_out <= `CDP_CLOCK_INACTIVE;
			config_clock_oe  <= 1'b0;
		end else begin
			case (state)
				ST_LOAD: begin
					config_clock_out <= active_scheme ? gen_level : `CDP_CLOCK_INACTIVE;
					config_clock_oe  <= active_scheme;
				end
				ST_USER: begin
					if (active_scheme & clock_release_en) begin
						config_clock_out <= user_clock_out;
						config_clock_oe  <= 1'b1;
					end else begin
						config_clock_out <= `CDP_CLOCK_INACTIVE;
						config_clock_oe  <= active_scheme;
					end
				end
				default: begin
					config_clock_out <= `CDP_CLOCK_INACTIVE;
					config_clock_oe  <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Flash select and completion flag.
	// ------------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flash_select_n           <= 1'b1;
			config_complete_flag_out <= 1'b0;
			config_complete_flag_oe  <= 1'b1;
		end else begin
			config_complete_flag_out <= 1'b0;
			config_complete_flag_oe  <= (state != ST_USER);
			flash_select_n           <= ~(loading & active_scheme);
		end
	end

	// ------------------------------------------------------------------------
	// User side of the data bus.
	// ------------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			user_data_in <= 16'h0000;
		end else begin
			user_data_in <= user_mode ? data_sync : 16'h0000;
		end
	end

	// ------------------------------------------------------------------------
	// Data bus pins.
	// ------------------------------------------------------------------------
	// Bit zero stays input in active serial only.
	assign user_mask = (scheme == `CDP_ACTIVE_SERIAL_SCHEME) ?
		`CDP_ACTIVE_SERIAL_USER_MASK : `CDP_FULL_USER_MASK;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			data_pin_out <= 16'h0000;
			data_pin_oe  <= `CDP_ALL_TRISTATE;
		end else begin
			case (state)
				ST_LOAD: begin
					data_pin_oe  <= `CDP_ALL_TRISTATE;
					data_pin_out <= 16'h0000;
					if (scheme == `CDP_ACTIVE_SERIAL_SCHEME) begin
						data_pin_oe[`CDP_COMMAND_BIT]  <= 1'b1;
						data_pin_out[`CDP_COMMAND_BIT] <= cmd_left ? cmd_shift[`CDP_CMD_MSB] : 1'b0;
					end
				end
				ST_USER: begin
					data_pin_out <= user_data_out;
					data_pin_oe  <= user_data_oe & user_mask;
					if (scheme == `CDP_ACTIVE_SERIAL_SCHEME) begin
						data_pin_oe[`CDP_COMMAND_BIT] <= 1'b1;
					end
				end
				default: begin
					data_pin_oe  <= `CDP_ALL_TRISTATE;
					data_pin_out <= 16'h0000;
				end
			endcase
		end
	end

endmodule // cdp_config_port

// ### logic/cdp_defs.vh
`ifndef CDP_DEFS_VH
`define CDP_DEFS_VH

// ----------------------------------------------------------------------------
// Configuration schemes
// ----------------------------------------------------------------------------
`define CDP_PASSIVE_SERIAL_SCHEME    2'h0
`define CDP_PASSIVE_PARALLEL_SCHEME  2'h1
`define CDP_ACTIVE_SERIAL_SCHEME     2'h2
`define CDP_ACTIVE_PARALLEL_SCHEME   2'h3

// ----------------------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------------------
`define CDP_ST_CAPTURE  2'h0
`define CDP_ST_LOAD     2'h1
`define CDP_ST_USER     2'h2
`define CDP_SETTLE_COUNT 2'h2

// ----------------------------------------------------------------------------
// Pin levels, widths and serial memory command
// ----------------------------------------------------------------------------
`define CDP_CLOCK_INACTIVE   1'b0
`define CDP_BUS_WIDTH        16
`define CDP_CMD_BITS         6'h20
`define CDP_CMD_MSB          31
`define CDP_READ_OPCODE      8'h03
`define CDP_READ_ADDRESS     24'h000000
`define CDP_SERIAL_BIT       0
`define CDP_COMMAND_BIT      1
`define CDP_LAST_BIT_INDEX   3'h7
`define CDP_BYTE_MSB         7
`define CDP_BYTE_PAD         8'h00
`define CDP_ALL_TRISTATE     16'h0000
`define CDP_ACTIVE_SERIAL_USER_MASK  16'hFFFE
`define CDP_FULL_USER_MASK   16'hFFFF

`endif

// ### logic/cdp_sync2.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Two flip-flop synchroniser for pin inputs.
// ----------------------------------------------------------------------------
module cdp_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk,
	input  wire             nrst,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stage1   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // cdp_sync2

// ### tb/cdp_chk_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pin checker of the configuration port.
// ----------------------------------------
module cdp_chk #(
	parameter CLOCK_HALF_PERIOD = 4
) (
	input wire		ref_clk,
	input wire		nrst,
	input wire		config_clock_out,
	input wire		config_clock_oe,
	input wire [15:0]	data_pin_oe,
	input wire		flash_select_n,
	input wire		config_complete_flag_out,
	input wire		config_complete_flag_oe,
	input wire		load_done,
	input wire		clock_release_en,
	input wire		user_mode,
	input wire [15:0]	cfg_data,
	input wire		cfg_data_valid,
	input wire		cfg_data_wide
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_sel; !user_mode && config_clock_oe |-> !flash_select_n; endproperty
	a_sel: assert property (p_sel) else $error("flash not selected while clocking");
	property p_pace; $rose(config_clock_out) && !user_mode |->
		(config_clock_out || user_mode)[*4] ##1 (!config_clock_out || user_mode); endproperty
	a_pace: assert property (p_pace) else $error("clock half period wrong");
	property p_hold; !user_mode |-> config_complete_flag_oe; endproperty
	a_hold: assert property (p_hold) else $error("flag released early");
	property p_release; $rose(user_mode) |=> !config_complete_flag_oe; endproperty
	a_release: assert property (p_release) else $error("flag not released");
	property p_low; config_complete_flag_oe |-> !config_complete_flag_out; endproperty
	a_low: assert property (p_low) else $error("flag driven high");
	property p_cause; $rose(user_mode) |-> $past(load_done); endproperty
	a_cause: assert property (p_cause) else $error("user mode without load done");
	property p_quiet; $past(user_mode) |-> !cfg_data_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("data taken after completion");
	property p_mask; !user_mode |-> data_pin_oe[15:2] == 14'h0000; endproperty
	a_mask: assert property (p_mask) else $error("upper data pins driven");
	property p_cmd; !user_mode && data_pin_oe[1] |-> config_clock_oe; endproperty
	a_cmd: assert property (p_cmd) else $error("command pin driven in passive scheme");
	property p_idle; user_mode && $past(user_mode) && config_clock_oe && !$past(clock_release_en)
		|-> !config_clock_out; endproperty
	a_idle: assert property (p_idle) else $error("clock not inactive");
	property p_pulse; cfg_data_valid |=> !cfg_data_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
	property p_byte; cfg_data_valid && !cfg_data_wide |-> cfg_data[15:8] == 8'h00; endproperty
	a_byte: assert property (p_byte) else $error("byte has upper bits");
	c_done: cover property ($rose(user_mode));
	c_wide: cover property (cfg_data_valid && cfg_data_wide);
	c_cmd: cover property (data_pin_oe[1] && !user_mode);
endmodule // cdp_chk

bind cdp_config_port cdp_chk #(.CLOCK_HALF_PERIOD(CLOCK_HALF_PERIOD)) i_cdp_chk (
	.ref_clk(ref_clk), .nrst(nrst), .config_clock_out(config_clock_out), .config_clock_oe(config_clock_oe),
	.data_pin_oe(data_pin_oe), .flash_select_n(flash_select_n), .load_done(load_done),
	.config_complete_flag_out(config_complete_flag_out), .config_complete_flag_oe(config_complete_flag_oe),
	.clock_release_en(clock_release_en), .user_mode(user_mode), .cfg_data(cfg_data),
	.cfg_data_valid(cfg_data_valid), .cfg_data_wide(cfg_data_wide));

// ### tb/cdp_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host or flash on the far side.
// ----------------------------------------
module cdp_far_end (
	input wire		go,
	input wire		active,
	input wire		serial,
	input wire [15:0]	pattern,
	input wire		clk_pin,
	input wire		cs_n,
	input wire		cmd_pin,
	output reg		host_clk,
	output wire [15:0]	host_data,
	output reg [31:0]	cmd_seen
);
	reg [2:0]	idx;
	integer		n_rise;
	wire		eff_clk = active ? clk_pin : host_clk;
	wire		rst_m = active ? cs_n : !go;
	initial host_clk = 1'b0;
	// Host clock runs in frames only.
	always begin
		if (go && !active) begin
			#200 host_clk <= 1'b1;
			#200 host_clk <= 1'b0;
		end else
			@(go or active);
	end
	always @(posedge eff_clk or posedge rst_m) begin
		if (rst_m) begin
			n_rise = 0;
			cmd_seen = 32'h00000000;
		end else if (active) begin
			if (n_rise < 32)
				cmd_seen = {cmd_seen[30:0], cmd_pin};
			n_rise = n_rise + 1;
		end
	end
	always @(negedge eff_clk or posedge rst_m) begin
		if (rst_m)
			idx <= 3'h0;
		else if (!active || n_rise > 33)
			idx <= idx + 3'h1;
	end
	assign host_data = rst_m ? ~pattern : serial ? {pattern[15:1], pattern[idx]} : pattern;
endmodule // cdp_far_end

// ### tb/tb.sv
`timescale 1ns/1ps
`include "cdp_defs.vh"
// ----------------------------------------
// Testbench of the configuration port.
// ----------------------------------------
module tb;
	reg		ref_clk, nrst, word_mode_strap, load_done, clock_release_en, go, act, ser;
	reg [1:0]	scheme_strap;
	reg [15:0]	pattern, user_data_oe;
	reg [51:0]	rows [0:4];
	wire		config_clock_out, config_clock_oe, flash_select_n, user_mode, host_clk;
	wire		config_complete_flag_out, config_complete_flag_oe, cfg_data_valid, cfg_data_wide;
	wire [15:0]	data_pin_out, data_pin_oe, user_data_in, cfg_data, host_data;
	wire [31:0]	cmd_seen;
	wire		clk_pin = config_clock_oe ? config_clock_out : host_clk;
	wire [15:0]	data_pin = (data_pin_oe & data_pin_out) | (~data_pin_oe & host_data);
	integer		error_cnt, n_tests, n_valid, cyc, r, k;

	cdp_config_port i_cdp_config_port (.ref_clk(ref_clk), .nrst(nrst), .scheme_strap(scheme_strap),
		.word_mode_strap(word_mode_strap), .config_clock_in(clk_pin), .config_clock_out(config_clock_out),
		.config_clock_oe(config_clock_oe), .data_pin_in(data_pin), .data_pin_out(data_pin_out),
		.data_pin_oe(data_pin_oe), .flash_select_n(flash_select_n), .load_done(load_done),
		.config_complete_flag_out(config_complete_flag_out), .config_complete_flag_oe(config_complete_flag_oe),
		.clock_release_en(clock_release_en), .user_clock_out(1'b1), .user_data_out(16'hA5A5),
		.user_data_oe(user_data_oe), .user_data_in(user_data_in), .user_mode(user_mode), .cfg_data(cfg_data),
		.cfg_data_valid(cfg_data_valid), .cfg_data_wide(cfg_data_wide));
	cdp_far_end i_cdp_far_end (.go(go), .active(act), .serial(ser), .pattern(pattern), .clk_pin(clk_pin),
		.cs_n(flash_select_n), .cmd_pin(data_pin[1]), .host_clk(host_clk), .host_data(host_data),
		.cmd_seen(cmd_seen));

	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cfg_data_valid === 1'b1)
			n_valid = n_valid + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			wrap_up;
		end
	end

	task check(input [15:0] got, input [15:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task wait_valid;
		begin
			k = 0;
			@(negedge ref_clk);
			while (cfg_data_valid !== 1'b1 && k < 2000) begin
				@(negedge ref_clk);
				k = k + 1;
			end
		end
	endtask

	task setup(input [51:0] row);
		begin
			@(posedge ref_clk);
			scheme_strap <= row[51:50];
			word_mode_strap <= row[49];
			pattern <= row[48:33];
			act <= row[51];
			ser <= ~row[50];
			go <= 1'b0;
			load_done <= 1'b0;
			clock_release_en <= 1'b0;
			nrst <= 1'b0;
			repeat (4) @(negedge ref_clk);
			check({12'h000, config_clock_oe, flash_select_n, config_complete_flag_oe, user_mode}, 16'h0006);
			@(posedge ref_clk);
			nrst <= 1'b1;
			repeat (4) @(posedge ref_clk);
			go <= 1'b1;
			wait_valid;
		end
	endtask

	task wrap_up;
		begin
			$display("errors %0d checks %0d", error_cnt, n_tests);
			if (error_cnt == 0 && n_tests > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		{word_mode_strap, load_done, clock_release_en, go, act, ser} = 6'h01;
		scheme_strap = 2'h0;
		pattern = 16'h0000;
		user_data_oe = 16'hF0F1;
		{error_cnt, n_tests, n_valid, cyc} = 128'h0;
		rows[0] = {`CDP_PASSIVE_SERIAL_SCHEME, 1'b0, 16'h00C6, 16'h00C6, 1'b0, 16'h0000};
		rows[1] = {`CDP_PASSIVE_PARALLEL_SCHEME, 1'b0, 16'h005A, 16'h005A, 1'b0, 16'h0000};
		rows[2] = {`CDP_ACTIVE_SERIAL_SCHEME, 1'b0, 16'h00C6, 16'h00C6, 1'b0, 16'h0002};
		rows[3] = {`CDP_ACTIVE_PARALLEL_SCHEME, 1'b0, 16'h3C96, 16'h0096, 1'b0, 16'h0000};
		rows[4] = {`CDP_ACTIVE_PARALLEL_SCHEME, 1'b1, 16'h3C96, 16'h3C96, 1'b1, 16'h0000};
		for (r = 0; r < 5; r = r + 1) begin
			setup(rows[r]);
			check(cfg_data, rows[r][32:17]);
			check({15'h0000, cfg_data_wide}, {15'h0000, rows[r][16]});
			check(data_pin_oe, rows[r][15:0]);
			if (rows[r][51:50] == `CDP_ACTIVE_SERIAL_SCHEME)
				check(cmd_seen[31:16], {`CDP_READ_OPCODE, 8'h00});
			@(posedge ref_clk);
			scheme_strap <= ~rows[r][51:50];
			repeat (6) @(negedge ref_clk);
			check({14'h0000, config_clock_oe, flash_select_n}, {14'h0000, act, ~act});
			@(posedge ref_clk);
			load_done <= 1'b1;
			@(posedge ref_clk);
			load_done <= 1'b0;
			go <= 1'b0;
			repeat (3) @(negedge ref_clk);
			check({13'h0000, user_mode, config_complete_flag_oe, flash_select_n}, 16'h0005);
			check(data_pin_oe, (rows[r][51:50] == `CDP_ACTIVE_SERIAL_SCHEME) ? 16'hF0F2 : 16'hF0F1);
			check(data_pin_out, 16'hA5A5);
			check({14'h0000, config_clock_oe, config_clock_out}, {14'h0000, act, 1'b0});
			@(posedge ref_clk);
			clock_release_en <= 1'b1;
			repeat (3) @(negedge ref_clk);
			check({15'h0000, config_clock_out}, {15'h0000, act});
			check(user_data_in, data_pin);
			n_valid = 0;
			@(posedge ref_clk);
			go <= 1'b1;
			repeat (40) @(negedge ref_clk);
			go <= 1'b0;
			check(n_valid[15:0], 16'h0000);
		end
		setup(rows[4]);
		@(posedge ref_clk);
		nrst <= 1'b0;
		@(negedge ref_clk);
		check({13'h0000, config_clock_oe, config_complete_flag_oe, cfg_data_valid}, 16'h0002);
		@(posedge ref_clk);
		nrst <= 1'b1;
		wait_valid;
		check(cfg_data, 16'h3C96);
		wrap_up;
	end
endmodule // tb
